// ### common/aid_pkg.sv
/*
  Package for the arithmetic instruction decode block: opcodes, lengths,
  cycle counts, operation codes and the carrier structs.
  Assumes a core that fetches opcode bytes and runs on ref_clk.
*/
// Functional notes
// - standard encodings, standard results and flags
// - cycle counts from this core's table
// - add: 28-2F,26-27 one; 25,24 two
// - addc: 38-3F,36-37 one; 35,34 two
// - subb: 98-9F,96-97 one; 95,94 two
// - inc: 04,08-0F,06-07 one; 05 two
// - dec: 14,18-1F,16-17 one; 15 two
// - inc dptr A3, one byte, three cycles
// - mul A4, div 84, five cycles
// - decimal adjust D4, one cycle
// - indirect address from R0 or R1
// - Rn in low bits; 8-bit immediate
// - psw bank bits pick register bank
`default_nettype none
package aid_pkg;
  localparam logic [7:0] OP_ADD_IMM = 8'h24;
  localparam logic [7:0] OP_ADD_DIR = 8'h25;
  localparam logic [7:0] OP_ADDC_IMM = 8'h34;
  localparam logic [7:0] OP_ADDC_DIR = 8'h35;
  localparam logic [7:0] OP_SUBB_IMM = 8'h94;
  localparam logic [7:0] OP_SUBB_DIR = 8'h95;
  localparam logic [7:0] OP_INC_ACC = 8'h04;
  localparam logic [7:0] OP_INC_DIR = 8'h05;
  localparam logic [7:0] OP_DEC_ACC = 8'h14;
  localparam logic [7:0] OP_DEC_DIR = 8'h15;
  localparam logic [7:0] OP_INC_DPTR = 8'ha3;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_DA = 8'hd4;
  // high nibble of register / indirect ranges
  localparam logic [3:0] GRP_ADD = 4'h2;
  localparam logic [3:0] GRP_ADDC = 4'h3;
  localparam logic [3:0] GRP_SUBB = 4'h9;
  localparam logic [3:0] GRP_INC = 4'h0;
  localparam logic [3:0] GRP_DEC = 4'h1;
  localparam logic [2:0] CYC_SHORT = 3'h1;
  localparam logic [2:0] CYC_LONG = 3'h2;
  localparam logic [2:0] CYC_DPTR = 3'h3;
  localparam logic [2:0] CYC_MULDIV = 3'h5;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam int PSW_BANK_LSB = 3;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] DPTR_RESET = 16'h0000;
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0, ALU_ADD = 4'h1, ALU_ADDC = 4'h2, ALU_SUBB = 4'h3,
    ALU_INC = 4'h4, ALU_DEC = 4'h5, ALU_INCDP = 4'h6, ALU_MUL = 4'h7,
    ALU_DIV = 4'h8, ALU_DA = 4'h9
  } aid_op_type;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_ACC = 3'h1, SRC_REG = 3'h2, SRC_IND = 3'h3,
    SRC_DIR = 3'h4, SRC_IMM = 3'h5
  } aid_src_type;

  typedef struct packed {
    aid_op_type op;
    aid_src_type src;
    logic [2:0] rsel;
    logic [1:0] len;
    logic [2:0] cycles;
    logic valid;
  } aid_dec_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] psw;
    logic [15:0] dptr;
  } aid_state_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] psw;
    logic [15:0] dptr;
    logic [7:0] mem;
    logic mem_we;
  } aid_result_type;
endpackage
`default_nettype wire

// ### src/aid_decode.sv
/*
  Combinational opcode decoder for the arithmetic group.
  Assumes the opcode byte comes from logic on the same clock.
*/
`default_nettype none
module aid_decode (
  input wire logic [7:0] opcode, // fetched opcode
  output aid_pkg::aid_dec_type dec // decoded fields
);
  always_comb begin
    dec = '0;
    dec.rsel = opcode[2:0];
    dec.len = aid_pkg::LEN_ONE;
    dec.cycles = aid_pkg::CYC_SHORT;
    dec.valid = 1'b1;
    if (opcode[3]) begin
      dec.src = aid_pkg::SRC_REG;
    end else if (opcode[2:1] == 2'b11) begin
      dec.src = aid_pkg::SRC_IND;
      dec.rsel = {2'b00, opcode[0]};
    end else if (opcode[2:0] == 3'h5) begin
      dec.src = aid_pkg::SRC_DIR;
      dec.len = aid_pkg::LEN_TWO;
      dec.cycles = aid_pkg::CYC_LONG;
    end else if (opcode[2:0] == 3'h4) begin
      dec.src = aid_pkg::SRC_IMM;
      dec.len = aid_pkg::LEN_TWO;
      dec.cycles = aid_pkg::CYC_LONG;
    end else begin
      dec.src = aid_pkg::SRC_NONE;
    end
    unique case (opcode[7:4])
      aid_pkg::GRP_ADD: dec.op = aid_pkg::ALU_ADD;
      aid_pkg::GRP_ADDC: dec.op = aid_pkg::ALU_ADDC;
      aid_pkg::GRP_SUBB: dec.op = aid_pkg::ALU_SUBB;
      aid_pkg::GRP_INC: dec.op = aid_pkg::ALU_INC;
      aid_pkg::GRP_DEC: dec.op = aid_pkg::ALU_DEC;
      default: dec.op = aid_pkg::ALU_NONE;
    endcase
    // inc and dec use 04/14 as the accumulator form
    if ((dec.op == aid_pkg::ALU_INC || dec.op == aid_pkg::ALU_DEC) &&
        dec.src == aid_pkg::SRC_IMM) begin
      dec.src = aid_pkg::SRC_ACC;
      dec.len = aid_pkg::LEN_ONE;
      dec.cycles = aid_pkg::CYC_SHORT;
    end
    if (dec.src == aid_pkg::SRC_NONE) begin
      dec.op = aid_pkg::ALU_NONE;
    end
    unique case (opcode)
      aid_pkg::OP_INC_DPTR: begin
        dec.op = aid_pkg::ALU_INCDP;
        dec.src = aid_pkg::SRC_NONE;
        dec.len = aid_pkg::LEN_ONE;
        dec.cycles = aid_pkg::CYC_DPTR;
      end
      aid_pkg::OP_MUL, aid_pkg::OP_DIV: begin
        dec.op = (opcode == aid_pkg::OP_MUL) ? aid_pkg::ALU_MUL
                                             : aid_pkg::ALU_DIV;
        dec.src = aid_pkg::SRC_NONE;
        dec.len = aid_pkg::LEN_ONE;
        dec.cycles = aid_pkg::CYC_MULDIV;
      end
      aid_pkg::OP_DA: begin
        dec.op = aid_pkg::ALU_DA;
        dec.src = aid_pkg::SRC_ACC;
        dec.len = aid_pkg::LEN_ONE;
        dec.cycles = aid_pkg::CYC_SHORT;
      end
      default: ;
    endcase
    if (dec.op == aid_pkg::ALU_NONE) begin
      dec.valid = 1'b0;
      dec.src = aid_pkg::SRC_NONE;
    end
  end
endmodule
`default_nettype wire

// ### src/aid_core.sv
/*
  Arithmetic instruction unit: decodes an opcode, works out the operand
  address, counts the instruction cycles and updates A, B, PSW and DPTR.
  Assumes the core supplies the immediate/direct operand byte, the
  fetched memory byte and a one-cycle enable per instruction cycle.
*/
`default_nettype none
module aid_core (
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic cyc_en, // one instruction-cycle tick
  input wire logic start, // opcode valid, unit idle
  input wire logic [7:0] opcode, // opcode byte
  input wire logic [7:0] operand, // byte after opcode
  input wire logic [7:0] mem_rdata, // operand byte read from memory
  output logic busy, // instruction in progress
  output logic done, // last cycle pulse
  output logic illegal, // opcode outside this group
  output logic [7:0] mem_addr, // internal memory address
  output logic [1:0] instr_len, // bytes of current instruction
  output logic mem_we, // write back to memory pulse
  output logic [7:0] mem_wdata, // write-back byte
  output aid_pkg::aid_state_type state // A, B, PSW, DPTR
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DONE = 2'b10
  } aid_fsm_type;

  aid_pkg::aid_dec_type dec, dec_q, dec_d;
  aid_fsm_type st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  aid_pkg::aid_state_type reg_q, reg_d;
  logic [7:0] opnd_q, opnd_d, addr_q, addr_d, wdata_q, wdata_d;
  logic we_q, we_d, ill_q, ill_d;
  aid_pkg::aid_result_type res;

  aid_decode u_dec (
    .opcode(opcode),
    .dec(dec)
  );

  // bank base plus register index
  function automatic logic [7:0] reg_addr(input logic [7:0] psw,
                                          input logic [2:0] idx);
    reg_addr = {3'b000, psw[aid_pkg::PSW_BANK_LSB +: 2], idx};
  endfunction

  // flag-exact add, standard 8-bit with aux carry and overflow
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    add8 = {s[8], h[4], ov, s[7:0]};
  endfunction

  function automatic logic [10:0] sub8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic bi);
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    s = {1'b0, a} - {1'b0, b} - {8'h00, bi};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
    ov = (a[7] != b[7]) && (s[7] != a[7]);
    sub8 = {s[8], h[4], ov, s[7:0]};
  endfunction

  // results computed from registered operands
  always_comb begin
    logic [10:0] r;
    logic [15:0] p;
    logic [8:0] t;
    logic cy;
    r = '0;
    p = '0;
    t = '0;
    cy = 1'b0;
    res.acc = reg_q.acc;
    res.b = reg_q.b;
    res.psw = reg_q.psw;
    res.dptr = reg_q.dptr;
    res.mem = opnd_q;
    res.mem_we = 1'b0;
    unique case (dec_q.op)
      aid_pkg::ALU_ADD, aid_pkg::ALU_ADDC: begin
        r = add8(reg_q.acc, opnd_q, (dec_q.op == aid_pkg::ALU_ADDC) &
                 reg_q.psw[aid_pkg::PSW_CY]);
        res.acc = r[7:0];
        res.psw[aid_pkg::PSW_CY] = r[10];
        res.psw[aid_pkg::PSW_AC] = r[9];
        res.psw[aid_pkg::PSW_OV] = r[8];
      end
      aid_pkg::ALU_SUBB: begin
        r = sub8(reg_q.acc, opnd_q, reg_q.psw[aid_pkg::PSW_CY]);
        res.acc = r[7:0];
        res.psw[aid_pkg::PSW_CY] = r[10];
        res.psw[aid_pkg::PSW_AC] = r[9];
        res.psw[aid_pkg::PSW_OV] = r[8];
      end
      aid_pkg::ALU_INC, aid_pkg::ALU_DEC: begin
        // no flags touched
        t[7:0] = (dec_q.op == aid_pkg::ALU_INC) ? opnd_q + 8'h01
                                                : opnd_q - 8'h01;
        if (dec_q.src == aid_pkg::SRC_ACC) begin
          res.acc = t[7:0];
        end else begin
          res.mem = t[7:0];
          res.mem_we = 1'b1;
        end
      end
      aid_pkg::ALU_INCDP: res.dptr = reg_q.dptr + 16'h0001;
      aid_pkg::ALU_MUL: begin
        p = reg_q.acc * reg_q.b;
        res.acc = p[7:0];
        res.b = p[15:8];
        res.psw[aid_pkg::PSW_CY] = 1'b0;
        res.psw[aid_pkg::PSW_OV] = |p[15:8];
      end
      aid_pkg::ALU_DIV: begin
        res.psw[aid_pkg::PSW_CY] = 1'b0;
        res.psw[aid_pkg::PSW_OV] = (reg_q.b == 8'h00);
        if (reg_q.b != 8'h00) begin
          res.acc = reg_q.acc / reg_q.b;
          res.b = reg_q.acc % reg_q.b;
        end
      end
      aid_pkg::ALU_DA: begin
        t = {1'b0, reg_q.acc};
        cy = reg_q.psw[aid_pkg::PSW_CY];
        if (t[3:0] > 4'h9 || reg_q.psw[aid_pkg::PSW_AC]) begin
          t = t + 9'h006;
        end
        cy = cy | t[8];
        if (t[7:4] > 4'h9 || cy) begin
          t = {1'b0, t[7:0]} + 9'h060;
        end
        res.acc = t[7:0];
        res.psw[aid_pkg::PSW_CY] = cy | t[8];
      end
      default: ;
    endcase
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dec_d = dec_q;
    reg_d = reg_q;
    opnd_d = opnd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    ill_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          ill_d = ~dec.valid;
          if (dec.valid) begin
            dec_d = dec;
            cnt_d = dec.cycles;
            st_d = ST_EXEC;
            unique case (dec.src)
              aid_pkg::SRC_REG: addr_d = reg_addr(reg_q.psw, dec.rsel);
              aid_pkg::SRC_IND: addr_d = mem_rdata;
              aid_pkg::SRC_DIR: addr_d = operand;
              default: addr_d = 8'h00;
            endcase
            opnd_d = (dec.src == aid_pkg::SRC_ACC) ? reg_q.acc : operand;
          end
        end
      end
      ST_EXEC: begin
        if (dec_q.src == aid_pkg::SRC_REG || dec_q.src == aid_pkg::SRC_DIR
            || dec_q.src == aid_pkg::SRC_IND) begin
          opnd_d = mem_rdata;
        end
        if (cyc_en) begin
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            st_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        reg_d.acc = res.acc;
        reg_d.b = res.b;
        reg_d.psw = res.psw;
        reg_d.dptr = res.dptr;
        we_d = res.mem_we;
        wdata_d = res.mem;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      dec_q <= '0;
      reg_q <= {aid_pkg::ACC_RESET, 8'h00, aid_pkg::PSW_RESET,
                aid_pkg::DPTR_RESET};
      opnd_q <= 8'h00;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dec_q <= dec_d;
      reg_q <= reg_d;
      opnd_q <= opnd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      ill_q <= ill_d;
    end
  end

  assign busy = (st_q != ST_IDLE);
  assign done = (st_q == ST_DONE);
  assign illegal = ill_q;
  assign mem_addr = addr_q;
  assign instr_len = dec_q.len;
  assign mem_we = we_q;
  assign mem_wdata = wdata_q;
  assign state = reg_q;
endmodule
`default_nettype wire

// ### sim/aid_core_monitor.sv
/*
  Port checker for the arithmetic instruction unit.
  Assumes it is bound to aid_core and that cyc_en ticks as driven.
*/
`default_nettype none
module aid_core_monitor (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic cyc_en, // cycle tick
  input wire logic start, // opcode valid
  input wire logic [7:0] opcode, // opcode byte
  input wire logic [7:0] operand, // following byte
  input wire logic [7:0] mem_rdata, // memory read byte
  input wire logic busy, // running
  input wire logic done, // last cycle
  input wire logic illegal, // not in group
  input wire logic [7:0] mem_addr, // operand address
  input wire logic [1:0] instr_len, // byte length
  input wire logic mem_we, // write back
  input wire logic [7:0] mem_wdata, // write-back byte
  input wire aid_pkg::aid_state_type state // A, B, PSW, DPTR
);
  wire logic tk;
  assign tk = start && !busy;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_done_pulse: assert property (
    done |=> !done) else $error("done held too long");
  a_illegal_flag: assert property (
    tk && opcode == 8'hd5 |=> illegal && !busy)
    else $error("foreign opcode not flagged");
  a_short_time: assert property (
    tk && opcode[7:3] == 5'h05 ##1 cyc_en |=> done)
    else $error("register add not one cycle");
  a_long_time: assert property (
    tk && opcode == 8'h25 ##1 cyc_en [*2] |=> done)
    else $error("direct add not two cycles");
  a_dptr_time: assert property (
    tk && opcode == 8'ha3 ##1 cyc_en [*3] |=> done)
    else $error("pointer increment not three cycles");
  a_mul_time: assert property (
    tk && opcode == 8'ha4 ##1 cyc_en [*5] |=> done)
    else $error("multiply not five cycles");
  a_muldiv_early: assert property (
    tk && (opcode == 8'ha4 || opcode == 8'h84) |=> !done [*5])
    else $error("multiply or divide ends early");
  a_da_time: assert property (
    tk && opcode == 8'hd4 ##1 cyc_en |=> done)
    else $error("decimal adjust not one cycle");
  a_reg_index: assert property (
    tk && opcode[7:3] == 5'h13 |=> instr_len == 2'h1 &&
    mem_addr == {3'h0, $past(state.psw[4:3]), $past(opcode[2:0])})
    else $error("register address wrong");
  a_ind_ptr: assert property (
    tk && opcode[7:1] == 7'h1b |=> mem_addr == $past(mem_rdata))
    else $error("indirect address not from pointer");
  a_imm_len: assert property (
    tk && (opcode == 8'h24 || opcode == 8'h34 || opcode == 8'h94)
    |=> instr_len == 2'h2) else $error("immediate length wrong");
endmodule
bind aid_core aid_core_monitor u_aid_core_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .cyc_en(cyc_en), .start(start),
  .opcode(opcode), .operand(operand), .mem_rdata(mem_rdata),
  .busy(busy), .done(done), .illegal(illegal), .mem_addr(mem_addr),
  .instr_len(instr_len), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .state(state));
`default_nettype wire

// ### sim/aid_tb_top.sv
/*
  Self-checking bench for aid_core; cyc_en high, half rate in t_slow.
  Assumes the package and design sources are compiled first.
*/
`default_nettype none
module aid_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic busy, done, illegal, mem_we, we_seen;
  logic [7:0] mem_addr, mem_wdata, wd_seen;
  logic [1:0] instr_len;
  aid_pkg::aid_state_type state;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic slow = 1'b0;
  logic cyc_en = 1'b1;
  always #2 ref_clk = ~ref_clk;
  // half-rate instruction-cycle tick while slow
  always @(posedge ref_clk) cyc_en <= slow ? ~cyc_en : 1'b1;
  aid_core u_aid_core (
    .ref_clk(ref_clk), .rst_n(rst_n), .cyc_en(cyc_en), .start(start),
    .opcode(opcode), .operand(operand), .mem_rdata(mem_rdata),
    .busy(busy), .done(done), .illegal(illegal), .mem_addr(mem_addr),
    .instr_len(instr_len), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .state(state));
  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [7:0] a, input logic [2:0] f);
    chk(16'(state.acc), 16'(a));
    chk(16'({state.psw[7], state.psw[6], state.psw[2]}), 16'(f));
  endtask
  task automatic ex(input logic [7:0] op, opnd, ptr, dat, input int n);
    int k;
    k = 0;
    we_seen = 1'b0;
    opcode = op;
    operand = opnd;
    mem_rdata = ptr;
    start = 1'b1;
    @(posedge ref_clk);
    #1 start = 1'b0;
    mem_rdata = dat;
    while (done !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1 k++;
      if (mem_we === 1'b1) begin
        we_seen = 1'b1;
        wd_seen = mem_wdata;
      end
    end
    chk(16'(k), 16'(n));
    @(posedge ref_clk);
    #1 chk(16'(busy), 16'h0000);
    // write-back pulse stands in the cycle after commit
    we_seen = mem_we;
    wd_seen = mem_wdata;
  endtask
  task automatic t_reset;
    chk(16'({busy, done, illegal, mem_we}), 16'h0000);
    chk(state.dptr, 16'h0000);
    chk({state.acc, state.psw}, 16'h0000);
  endtask
  task automatic t_add;
    ex(8'h24, 8'h7f, 8'h00, 8'h00, 2);
    st(8'h7f, 3'h0);
    chk(16'(instr_len), 16'h0002);
    ex(8'h25, 8'h40, 8'h00, 8'h01, 2);
    st(8'h80, 3'h3);
    chk(16'(mem_addr), 16'h0040);
    ex(8'h2a, 8'h00, 8'h00, 8'h80, 1);
    st(8'h00, 3'h5);
    chk(16'(mem_addr), 16'h0002);
    ex(8'h36, 8'h00, 8'h55, 8'h0f, 1);
    st(8'h10, 3'h2);
    chk(16'(mem_addr), 16'h0055);
    ex(8'h34, 8'hf0, 8'h00, 8'h00, 2);
    st(8'h00, 3'h4);
    ex(8'h94, 8'h01, 8'h00, 8'h00, 2);
    st(8'hfe, 3'h6);
    ex(8'h9f, 8'h00, 8'h00, 8'h7e, 1);
    st(8'h7f, 3'h3);
    chk(16'(mem_addr), 16'h0007);
  endtask
  task automatic t_incdec;
    ex(8'h04, 8'h00, 8'h00, 8'h00, 1);
    st(8'h80, 3'h3);
    ex(8'h14, 8'h00, 8'h00, 8'h00, 1);
    st(8'h7f, 3'h3);
    ex(8'h0d, 8'h00, 8'h00, 8'hff, 1);
    chk(16'({we_seen, wd_seen}), 16'h0100);
    chk(16'(mem_addr), 16'h0005);
    ex(8'h16, 8'h00, 8'h30, 8'h00, 1);
    chk(16'({we_seen, wd_seen}), 16'h01ff);
    chk(16'(mem_addr), 16'h0030);
    ex(8'h05, 8'h20, 8'h00, 8'h41, 2);
    chk(16'({we_seen, wd_seen}), 16'h0142);
    ex(8'h15, 8'h21, 8'h00, 8'h10, 2);
    chk(16'({we_seen, wd_seen}), 16'h010f);
    chk(16'(mem_addr), 16'h0021);
    st(8'h7f, 3'h3);
  endtask
  task automatic t_refuse;
    int n;
    n = 0;
    opcode = 8'h04;
    start = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 start = 1'b0;
    n = int'(done === 1'b1);
    repeat (8) begin
      @(posedge ref_clk);
      #1 n += int'(done === 1'b1);
    end
    chk(16'(n), 16'h0001);
    st(8'h80, 3'h3);
  endtask
  task automatic t_illegal;
    opcode = 8'hd5;
    start = 1'b1;
    @(posedge ref_clk);
    #1 start = 1'b0;
    chk(16'({illegal, busy}), 16'h0002);
    @(posedge ref_clk);
    #1 chk(16'({illegal, busy}), 16'h0000);
    st(8'h80, 3'h3);
  endtask
  task automatic t_misc;
    ex(8'hd4, 8'h00, 8'h00, 8'h00, 1);
    st(8'h86, 3'h3);
    ex(8'ha3, 8'h00, 8'h00, 8'h00, 3);
    chk(state.dptr, 16'h0001);
    chk(16'(instr_len), 16'h0001);
    ex(8'ha4, 8'h00, 8'h00, 8'h00, 5);
    st(8'h00, 3'h2);
    chk(16'(state.b), 16'h0000);
    ex(8'h84, 8'h00, 8'h00, 8'h00, 5);
    chk(16'({state.psw[7], state.psw[2]}), 16'h0001);
  endtask
  task automatic t_slow;
    slow = 1'b1;
    ex(8'ha3, 8'h00, 8'h00, 8'h00, 6);
    chk(state.dptr, 16'h0002);
    ex(8'h25, 8'h41, 8'h00, 8'h05, 4);
    st(8'h05, 3'h0);
    chk(16'(mem_addr), 16'h0041);
    slow = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_add;
    t_incdec;
    t_refuse;
    t_illegal;
    t_misc;
    t_slow;
    final_report;
  end
endmodule
`default_nettype wire
